//--- fbs_sram_port.sv
/*
  Flow-through burst SRAM access port with internal storage array.
  Assumes a synchronous bus master on sys_clk; oe_n and sleep_request
  are asynchronous and act combinationally on the data outputs.
*/
// Behaviour
// - All synchronous inputs except burst_order registered on rising edge
// - Two-bit counter seeded with burst start
// - Mode high interleaved, low linear order
// - Either address strobe starts a burst
// - Counter advances only on advance input
// - Address, enables registered only on strobe
// - Output enable and sleep are asynchronous
// - Burst rate two-one-one-one cycles
// - Split data bus, 36-bit dq_in and dq_out, with dq_oe
// - Strobe plus all enables seed counter
// - Byte writes only where qualified lanes
`timescale 1ns/1ps
module fbs_sram_port
  import fbs_pkg::*;
#(
  parameter int DATA_W = FBS_DATA_W,
  parameter int ADDR_W = FBS_ADDR_W,
  parameter int LANES  = FBS_LANES,
  parameter int MEM_AW = 8
)(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              chip_sel_primary_n,
  input  wire logic              depth_sel_high,
  input  wire logic              depth_sel_low_n,
  input  wire logic              proc_addr_strobe_n,
  input  wire logic              ctrl_addr_strobe_n,
  input  wire logic              burst_advance_n,
  input  wire logic [LANES-1:0]  lane_write_sel_n,
  input  wire logic              lane_write_qualify_n,
  input  wire logic              all_lanes_write_n,
  input  wire logic              burst_order,
  input  wire logic              oe_n,
  input  wire logic              sleep_request,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe
);
  localparam int LANE_W = DATA_W / LANES;

  // ===========================================================
  // Input registers
  logic [ADDR_W-1:0] r_addr;
  logic              r_sel_n;
  logic              r_dep_hi;
  logic              r_dep_lo_n;
  logic              r_ps_n;
  logic              r_cs_n;
  logic              r_step_n;
  logic [LANES-1:0]  r_bw_n;
  logic              r_qual_n;
  logic              r_allw_n;
  logic [DATA_W-1:0] r_din;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      r_addr     <= '0;
      r_sel_n    <= 1'h1;
      r_dep_hi   <= 1'h0;
      r_dep_lo_n <= 1'h1;
      r_ps_n     <= 1'h1;
      r_cs_n     <= 1'h1;
      r_step_n   <= 1'h1;
      r_bw_n     <= '1;
      r_qual_n   <= 1'h1;
      r_allw_n   <= 1'h1;
      r_din      <= '0;
    end else begin
      r_addr     <= addr;
      r_sel_n    <= chip_sel_primary_n;
      r_dep_hi   <= depth_sel_high;
      r_dep_lo_n <= depth_sel_low_n;
      r_ps_n     <= proc_addr_strobe_n;
      r_cs_n     <= ctrl_addr_strobe_n;
      r_step_n   <= burst_advance_n;
      r_bw_n     <= lane_write_sel_n;
      r_qual_n   <= lane_write_qualify_n;
      r_allw_n   <= all_lanes_write_n;
      r_din      <= dq_in;
    end
  end

  // ===========================================================
  // Burst control
  logic strobe;
  logic enabled;
  logic start;

  assign strobe  = !r_ps_n || !r_cs_n;
  assign enabled = !r_sel_n && r_dep_hi && !r_dep_lo_n;
  assign start   = strobe && enabled;

  typedef enum logic [1:0] {
    FBS_IDLE  = 2'b01,
    FBS_BURST = 2'b10
  } fbs_state_t;

  fbs_state_t        state;
  fbs_state_t        next_state;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;

  fbs_burst_if bif ();

  always_comb begin
    next_state = state;
    next_base  = base;
    case (state)
      FBS_IDLE: begin
        if (start) begin
          next_state = FBS_BURST;
        end
      end
      FBS_BURST: begin
        // Strobe without enables deselects the part
        if (strobe && !enabled) begin
          next_state = FBS_IDLE;
        end
      end
      default: next_state = FBS_IDLE;
    endcase
    if (start) begin
      next_base = r_addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= FBS_IDLE;
      base  <= '0;
    end else begin
      state <= next_state;
      base  <= next_base;
    end
  end

  assign bif.load     = start;
  assign bif.seed     = r_addr[1:0];
  assign bif.step     = !start && !r_step_n && (state == FBS_BURST);
  assign bif.order_il = burst_order;

  fbs_burst_counter fbs_burst_counter_i (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .bif     (bif.cnt)
  );

  // ===========================================================
  // Storage and write path
  logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];
  logic [MEM_AW-1:0] cur_addr;
  logic [ADDR_W-1:0] full_addr;
  logic              active;
  logic [LANES-1:0]  lane_we;

  assign full_addr = {base[ADDR_W-1:FBS_CNT_W], bif.low_addr};
  assign cur_addr  = full_addr[MEM_AW-1:0];
  assign active    = (state == FBS_BURST) && !sleep_request;

  always_comb begin
    if (!r_allw_n) begin
      lane_we = '1;
    end else if (!r_qual_n) begin
      lane_we = ~r_bw_n;
    end else begin
      lane_we = '0;
    end
  end

  // Write lands the cycle after data is captured, one cycle after the address
  always_ff @(posedge sys_clk) begin
    if (active && !start) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_we[i]) begin
          mem[cur_addr][i*LANE_W +: LANE_W] <= r_din[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ===========================================================
  // Flow-through read, async output enable and sleep
  logic reading;
  logic rd_q;
  logic next_rd_q;

  assign reading   = active && !start && (lane_we == '0);
  assign next_rd_q = reading;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_q   <= 1'h0;
      dq_out <= '0;
    end else begin
      rd_q   <= next_rd_q;
      dq_out <= mem[cur_addr];
    end
  end

  // Combinational gate so oe_n and sleep act without the clock
  assign dq_oe = rd_q && !oe_n && !sleep_request;

  a_oe_floats: assert property (@(posedge sys_clk) disable iff (!rstn)
    oe_n |-> !dq_oe)
    else $error("data bus driven with output enable off");
  a_start_loads: assert property (@(posedge sys_clk) disable iff (!rstn)
    start |=> (state == FBS_BURST && bif.count == FBS_CNT_ZERO))
    else $error("burst start did not load counter");
  a_no_adv_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!start && r_step_n) |=> $stable(bif.count))
    else $error("counter moved without advance");
  a_base_strobe: assert property (@(posedge sys_clk) disable iff (!rstn)
    !start |=> $stable(base))
    else $error("address captured without strobe");
  a_either_strobe: assert property (@(posedge sys_clk) disable iff (!rstn)
    (enabled && (!r_ps_n ^ !r_cs_n)) |=> state == FBS_BURST)
    else $error("single strobe did not start burst");
  a_linear_seq: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!burst_order && bif.step && !bif.load) ##1 !burst_order |->
      bif.low_addr == $past(bif.low_addr) + FBS_CNT_ONE)
    else $error("linear order wrong");
  a_il_seq: assert property (@(posedge sys_clk) disable iff (!rstn)
    (start && burst_order) ##1 burst_order |->
      bif.low_addr == $past(r_addr[1:0]))
    else $error("interleaved first address wrong");
  a_read_rate: assert property (@(posedge sys_clk) disable iff (!rstn)
    (reading && !oe_n && !sleep_request) ##1 (!oe_n && !sleep_request)
      |-> dq_oe)
    else $error("read data not driven next cycle");
endmodule

//--- fbs_pkg.sv
/*
  Shared constants for the flow-through burst SRAM port.
  Assumes nothing of its surroundings.
*/
package fbs_pkg;
  localparam int FBS_DATA_W  = 36;
  localparam int FBS_ADDR_W  = 19;
  localparam int FBS_LANES   = 4;
  localparam int FBS_CNT_W   = 2;
  localparam logic [1:0] FBS_CNT_ZERO = 2'h0;
  localparam logic [1:0] FBS_CNT_ONE  = 2'h1;
  localparam logic [1:0] FBS_CNT_LAST = 2'h3;
endpackage

//--- fbs_burst_if.sv
/*
  Interface between the port top and its burst address counter.
  Assumes one clock, sys_clk, drives both ends.
*/
`timescale 1ns/1ps
interface fbs_burst_if;
  logic       load;
  logic       step;
  logic       order_il;
  logic [1:0] seed;
  logic [1:0] low_addr;
  logic [1:0] count;
  modport ctl (output load, output step, output order_il, output seed,
               input low_addr, input count);
  modport cnt (input load, input step, input order_il, input seed,
               output low_addr, output count);
endinterface

//--- fbs_burst_counter.sv
/*
  Two-bit burst address counter, linear or interleaved order.
  Assumes load and step are qualified by the caller on sys_clk.
*/
`timescale 1ns/1ps
module fbs_burst_counter
  import fbs_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  rstn,
  fbs_burst_if.cnt   bif
);
  logic [1:0] seed;
  logic [1:0] count;
  logic [1:0] next_seed;
  logic [1:0] next_count;

  always_comb begin
    next_seed  = seed;
    next_count = count;
    if (bif.load) begin
      next_seed  = bif.seed;
      next_count = FBS_CNT_ZERO;
    end else if (bif.step) begin
      next_count = count + FBS_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      seed  <= FBS_CNT_ZERO;
      count <= FBS_CNT_ZERO;
    end else begin
      seed  <= next_seed;
      count <= next_count;
    end
  end

  // Interleave xors the count in, linear adds it
  assign bif.low_addr = bif.order_il ? (seed ^ count)
                                     : (seed + count);
  assign bif.count    = count;

  a_count_wraps: assert property (@(posedge sys_clk) disable iff (!rstn)
    (bif.step && !bif.load && count == FBS_CNT_LAST) |=>
      count == FBS_CNT_ZERO)
    else $error("burst count did not wrap");
endmodule

//--- fbs_bus_master.sv
/*
  Bus master model driving the burst SRAM port; keeps a word image
  and queues the read data each burst should return.
  Assumes one clock, sys_clk, and oe_n held steady across a burst.
*/
`timescale 1ns/1ps
module fbs_bus_master
  import fbs_pkg::*;
(
  input  wire logic sys_clk
);
  logic [FBS_ADDR_W-1:0] addr                 = 19'h0;
  logic                  chip_sel_primary_n   = 1'h0;
  logic                  depth_sel_high       = 1'h1;
  logic                  depth_sel_low_n      = 1'h0;
  logic                  proc_addr_strobe_n   = 1'h1;
  logic                  ctrl_addr_strobe_n   = 1'h1;
  logic                  burst_advance_n      = 1'h1;
  logic [FBS_LANES-1:0]  lane_write_sel_n     = 4'hF;
  logic                  lane_write_qualify_n = 1'h1;
  logic                  all_lanes_write_n    = 1'h1;
  logic                  burst_order          = 1'h0;
  logic                  oe_n                 = 1'h0;
  logic                  sleep_request        = 1'h0;
  logic [FBS_DATA_W-1:0] dq_in                = 36'h0;
  logic [FBS_DATA_W-1:0] mem [256];
  logic [FBS_DATA_W-1:0] exp_q [$];
  // ==========================================================
  // Bus cycles
  task automatic strobe(input logic [7:0] a, input logic ok);
    @(posedge sys_clk);
    addr <= {11'h0, a};
    chip_sel_primary_n <= 1'h0;
    depth_sel_high <= ok;
    // Odd addresses use the controller strobe, even ones the processor's
    ctrl_addr_strobe_n <= ~a[0];
    proc_addr_strobe_n <= a[0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [35:0] d,
                    input logic [3:0] sel_n, input logic ok);
    logic [35:0] m;
    m = mem[a];
    strobe(a, ok);
    @(posedge sys_clk);
    // Deselect rides with the write so no read cycle trails the burst
    {proc_addr_strobe_n, ctrl_addr_strobe_n} <= 2'h2;
    chip_sel_primary_n <= 1'h1;
    dq_in <= d;
    lane_write_sel_n <= sel_n;
    if (sel_n == 4'h0) all_lanes_write_n <= 1'h0;
    else lane_write_qualify_n <= 1'h0;
    @(posedge sys_clk);
    {all_lanes_write_n, lane_write_qualify_n} <= 2'h3;
    ctrl_addr_strobe_n <= 1'h1;
    lane_write_sel_n <= 4'hF;
    // Released data flips so a late sample cannot pass by luck
    dq_in <= ~d;
    for (int i = 0; i < 4; i++) if (!sel_n[i]) m[9*i +: 9] = d[9*i +: 9];
    if (ok) mem[a] = m;
  endtask
  task automatic rd(input logic [7:0] a, input logic ok);
    strobe(a, ok);
    for (int k = 0; k < 4; k++) begin
      if (ok && !oe_n && !sleep_request)
        exp_q.push_back(mem[{a[7:2], burst_order ?
          a[1:0] ^ k[1:0] : a[1:0] + k[1:0]}]);
      @(posedge sys_clk);
      // Last beat deselects, so the part stops reading after word three
      {proc_addr_strobe_n, ctrl_addr_strobe_n} <= (k == 3) ? 2'h2 : 2'h3;
      chip_sel_primary_n <= (k == 3);
      burst_advance_n <= (k == 3);
    end
  endtask
endmodule

//--- fbs_sram_port_tb.sv
/*
  Self-checking bench for the burst SRAM port.
  Assumes the master model drives every port input but sys_clk and rstn.
*/
`timescale 1ns/1ps
module fbs_sram_port_tb
  import fbs_pkg::*;
;
  logic                  sys_clk     = 1'h0;
  logic                  rstn        = 1'h0;
  logic [FBS_DATA_W-1:0] dq_out;
  logic                  dq_oe;
  int                    n_errors    = 0;
  int                    comparisons = 0;
  int                    cycles      = 0;
  always #20 sys_clk = ~sys_clk;
  fbs_bus_master fbs_bus_master_i (.sys_clk(sys_clk));
  fbs_sram_port fbs_sram_port_i (
    .sys_clk(sys_clk), .rstn(rstn), .addr(fbs_bus_master_i.addr),
    .chip_sel_primary_n(fbs_bus_master_i.chip_sel_primary_n),
    .depth_sel_high(fbs_bus_master_i.depth_sel_high),
    .depth_sel_low_n(fbs_bus_master_i.depth_sel_low_n),
    .proc_addr_strobe_n(fbs_bus_master_i.proc_addr_strobe_n),
    .ctrl_addr_strobe_n(fbs_bus_master_i.ctrl_addr_strobe_n),
    .burst_advance_n(fbs_bus_master_i.burst_advance_n),
    .lane_write_sel_n(fbs_bus_master_i.lane_write_sel_n),
    .lane_write_qualify_n(fbs_bus_master_i.lane_write_qualify_n),
    .all_lanes_write_n(fbs_bus_master_i.all_lanes_write_n),
    .burst_order(fbs_bus_master_i.burst_order),
    .oe_n(fbs_bus_master_i.oe_n),
    .sleep_request(fbs_bus_master_i.sleep_request),
    .dq_in(fbs_bus_master_i.dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  // ==========================================================
  // Checking
  task automatic check(input string name, input logic [35:0] got,
                       input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [35:0] rnd36();
    return {4'($urandom), $urandom};
  endfunction
  // Every driven word must be one the master queued, in order
  always @(negedge sys_clk) begin
    if (dq_oe === 1'h1) begin
      if (fbs_bus_master_i.exp_q.size() == 0)
        check("dq_oe", {35'h0, dq_oe}, 36'h0);
      else
        check("dq_out", dq_out, fbs_bus_master_i.exp_q.pop_front());
    end
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      stop_test();
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(54192));
    repeat (16) @(posedge sys_clk);
    rstn <= 1'h1;
    for (int i = 0; i < 8; i++)
      fbs_bus_master_i.wr(8'h10 + 8'(i), rnd36(), 4'h0, 1'h1);
    fbs_bus_master_i.wr(8'h11, rnd36(), 4'hA, 1'h1);
    fbs_bus_master_i.wr(8'h12, rnd36(), 4'h0, 1'h0);
    for (int o = 0; o < 2; o++) begin
      repeat (3) @(posedge sys_clk);
      fbs_bus_master_i.burst_order <= o[0];
      for (int s = 0; s < 8; s++)
        fbs_bus_master_i.rd(8'h10 + 8'(s), 1'h1);
    end
    fbs_bus_master_i.rd(8'h10, 1'h0);
    fbs_bus_master_i.oe_n <= 1'h1;
    fbs_bus_master_i.rd(8'h13, 1'h1);
    @(negedge sys_clk);
    check("dq_oe", {35'h0, dq_oe}, 36'h0);
    repeat (4) @(posedge sys_clk);
    fbs_bus_master_i.oe_n <= 1'h0;
    fbs_bus_master_i.sleep_request <= 1'h1;
    fbs_bus_master_i.rd(8'h14, 1'h1);
    @(negedge sys_clk);
    check("dq_oe_sleep", {35'h0, dq_oe}, 36'h0);
    repeat (4) @(posedge sys_clk);
    fbs_bus_master_i.sleep_request <= 1'h0;
    repeat (8) @(posedge sys_clk);
    check("queue", 36'(fbs_bus_master_i.exp_q.size()), 36'h0);
    stop_test();
  end
endmodule
